// file: hw/ocm_top.sv
// over-range status pins with channel C clock-out mux and register slave
`timescale 1ns/100ps
`include "ocm_defines.svh"
module ocm_top
    import ocm_pkg::*;
#(
    parameter int NUM_CHANNELS = 4 // 1, 2 or 4 converter channels
) (
    input wire logic clk,
    input wire logic resetn,
    // register bus
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    // converter codes
    input wire logic [11:0] sample_a,
    input wire logic [11:0] sample_b,
    input wire logic [11:0] sample_c,
    // reference clock path and straps
    input wire logic ref_clk_diff,
    input wire logic ref_clk_se,
    input wire logic ref_select_se,
    input wire logic pll_enable,
    input wire logic power_down_pin,
    input wire logic [1:0] clock_output_select,
    // status and clock pins
    output logic overrange_out_a,
    output logic overrange_out_b,
    output logic overrange_or_clock_out_c,
    output logic reference_clock_repeat_out
);

    // effective source of the channel C pin
    function automatic ocm_clksrc_t ocm_eff_src(
        input logic [1:0] pins,
        input logic [`OCM_CTRL_W-1:0] ctrl,
        input logic pll_en
    );
        logic [1:0] sel;
        sel = ctrl[`OCM_CTRL_OVR_EN] ? ctrl[`OCM_CTRL_SEL_HI:`OCM_CTRL_SEL_LO] : pins;
        if (ctrl[`OCM_CTRL_DIS] || !pll_en) begin
            sel = 2'b00;
        end
        return ocm_clksrc_t'(sel);
    endfunction

    // the source choice is decoded in one place and used by the pin mux and the state
    // word alike, so the two never disagree about what the pin carries; the disable bit
    // and a low pll enable both force over-range use whatever the straps say
    // over-range timing, from the edge that sees a code above the trip level: the
    // stretcher level rises on that edge, the pin one edge after that, and the sticky
    // status bit with it; irq rises with them as it is registered from the next
    // status. the extra pin stage costs a cycle of latency but keeps every pin
    // straight off a flip-flop, so board logic sees no glitch from the mux
    // ---------------- per-channel stretchers ----------------
    logic [11:0] samples [`OCM_NCH]; // codes in channel order
    logic [`OCM_NCH-1:0] ch_level; // stretched levels
    logic [`OCM_NCH-1:0] ch_rise; // assertion pulses
    logic [`OCM_NCH-1:0] ch_active; // channels present in variant

    assign samples[0] = sample_a;
    assign samples[1] = sample_b;
    assign samples[2] = sample_c;
    assign ch_active[0] = 1'b1;
    assign ch_active[1] = (NUM_CHANNELS >= 2);
    assign ch_active[2] = (NUM_CHANNELS == 4);

    logic [`OCM_CTRL_W-1:0] ctrl_r, ctrl_nxt; // clock-out override and disable
    logic [11:0] thresh_r, thresh_nxt; // trip level
    logic [7:0] minp_r, minp_nxt; // minimum pulse in cycles

    // variants are a parameter, not logic: a channel the variant lacks keeps its
    // stretcher but holds it idle, so its over-range level and status bit stay low for good
    // one stretcher per channel, all sharing threshold and pulse length
    for (genvar i = 0; i < `OCM_NCH; i++) begin : g_ch
        ocm_chan_if ch_if ();
        assign ch_if.sample = samples[i];
        assign ch_if.threshold = thresh_r;
        assign ch_if.min_pulse = minp_r;
        assign ch_if.active = ch_active[i];
        assign ch_level[i] = ch_if.level;
        assign ch_rise[i] = ch_if.rise;
        ocm_stretch u_stretch (
            .clk(clk),
            .resetn(resetn),
            .bus(ch_if.chan)
        );
    end

    // ---------------- reference clock path ----------------
    // references are sampled as ordinary synchronous inputs; this limits the forwarded
    // clock to below half the block clock and gives it one block cycle of jitter, a
    // limitation users of the pin must accept. the divider counts rising edges of the
    // sampled reference, so bit 0 is half and bit 1 a quarter of its rate at no cost;
    // power down clears it so both divided clocks restart from a known phase
    logic ref_r, ref_nxt; // sample of the selected reference
    logic ref_prev_r, ref_prev_nxt; // previous sample, for edges
    logic [1:0] div_r, div_nxt; // reference rising-edge counter
    logic refo_r, refo_nxt; // repeat output
    ocm_clksrc_t src; // current channel C source

    assign src = ocm_eff_src(clock_output_select, ctrl_r, pll_enable);

    // pick reference and count its edges
    always_comb begin
        ref_nxt = ref_select_se ? ref_clk_se : ref_clk_diff;
        ref_prev_nxt = ref_r;
        div_nxt = div_r;
        refo_nxt = 1'b0;
        if (power_down_pin) begin
            div_nxt = 2'b00;
        end else begin
            if (ref_r && !ref_prev_r) begin
                div_nxt = div_r + 2'b01;
            end
            refo_nxt = pll_enable && ref_r;
        end
    end

    // the previous sample is the edge detector; both reset low, so a reference that
    // idles high out of reset gives one early count, harmless for a free clock
    // reference registers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ref_r <= 1'b0;
            ref_prev_r <= 1'b0;
            div_r <= 2'b00;
            refo_r <= 1'b0;
        end else begin
            ref_r <= ref_nxt;
            ref_prev_r <= ref_prev_nxt;
            div_r <= div_nxt;
            refo_r <= refo_nxt;
        end
    end

    // ---------------- output pins ----------------
    logic ora_r, ora_nxt; // channel A pin
    logic orb_r, orb_nxt; // channel B pin
    logic orc_r, orc_nxt; // channel C pin

    // pin C is the only shared pin: over-range level or one of three clocks, chosen every
    // cycle from the live straps, the control word and the enable. switching mid-period
    // can leave one short phase on the pin; the far side should skip the first few edges
    // after a change of source
    // pin mux; the straps are live so the clock runs without any write
    always_comb begin
        ora_nxt = ch_level[0];
        orb_nxt = ch_level[1];
        case (src)
            OCM_SRC_OVR: orc_nxt = ch_level[2];
            OCM_SRC_REPEAT: orc_nxt = ref_r;
            OCM_SRC_DIV2: orc_nxt = div_r[0];
            OCM_SRC_DIV4: orc_nxt = div_r[1];
            default: orc_nxt = ch_level[2];
        endcase
        if (src != OCM_SRC_OVR && power_down_pin) begin
            orc_nxt = 1'b0;
        end
    end

    // the pin stage is where over-range and clock meet; its reset keeps all pins low
    // until the first edge after release, so board logic never sees a stray pulse
    // pin registers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ora_r <= 1'b0;
            orb_r <= 1'b0;
            orc_r <= 1'b0;
        end else begin
            ora_r <= ora_nxt;
            orb_r <= orb_nxt;
            orc_r <= orc_nxt;
        end
    end

    assign overrange_out_a = ora_r;
    assign overrange_out_b = orb_r;
    assign overrange_or_clock_out_c = orc_r;
    assign reference_clock_repeat_out = refo_r;

    // ---------------- register slave ----------------
    // register map, 32-bit words at word-aligned byte addresses:
    //   0x00 control: bit 0 override enable, bits 2:1 override source, bit 3 clock disable
    //   0x04 trip level, 12 bits; codes strictly above it count as over-range
    //   0x08 minimum pulse in cycles, 8 bits; zero behaves as one
    //   0x0C sticky assertion events of A, B, C; write one to clear
    //   0x10 interrupt mask, same layout as the events
    //   0x14 read only: bits 2:0 the pins, bits 5:4 the effective pin C source
    // every access sees exactly one wait state: waitrequest drops for one cycle after the
    // request is seen, read data stand in that same cycle; a master may start its next
    // access on the edge after the answer, so back-to-back accesses take two cycles each
    logic wait_r, wait_nxt; // waitrequest, low for one answer cycle
    logic [31:0] rdata_r, rdata_nxt; // read data
    logic [2:0] status_r, status_nxt; // sticky over-range events
    logic [2:0] mask_r, mask_nxt; // interrupt enables
    logic irq_r, irq_nxt; // interrupt level
    logic req; // request pending
    logic wr_take; // write lands this edge

    assign req = avs_read || avs_write;
    // a write is committed only on the edge that sees waitrequest low
    assign wr_take = avs_write && !wait_r;

    // bus handshake, register writes, status and interrupt
    always_comb begin
        wait_nxt = 1'b1;
        rdata_nxt = rdata_r;
        ctrl_nxt = ctrl_r;
        thresh_nxt = thresh_r;
        minp_nxt = minp_r;
        mask_nxt = mask_r;
        status_nxt = status_r;
        // answer one cycle after the request is seen
        if (req && wait_r) begin
            wait_nxt = 1'b0;
            rdata_nxt = 32'h0000_0000;
            if (avs_read) begin
                if (avs_address == `OCM_ADDR_CTRL) begin
                    rdata_nxt[`OCM_CTRL_W-1:0] = ctrl_r;
                end else if (avs_address == `OCM_ADDR_THRESH) begin
                    rdata_nxt[11:0] = thresh_r;
                end else if (avs_address == `OCM_ADDR_MINP) begin
                    rdata_nxt[7:0] = minp_r;
                end else if (avs_address == `OCM_ADDR_STATUS) begin
                    rdata_nxt[2:0] = status_r;
                end else if (avs_address == `OCM_ADDR_MASK) begin
                    rdata_nxt[2:0] = mask_r;
                end else if (avs_address == `OCM_ADDR_STATE) begin
                    rdata_nxt[2:0] = {orc_r, orb_r, ora_r};
                    rdata_nxt[`OCM_STATE_SRC_HI:`OCM_STATE_SRC_LO] = src;
                end
                // unmapped addresses read as zero
            end
        end
        // writes land only on the edge that samples waitrequest low, never while the
        // master still waits, so a held request cannot be applied twice
        if (wr_take) begin
            if (avs_address == `OCM_ADDR_CTRL) begin
                ctrl_nxt = avs_writedata[`OCM_CTRL_W-1:0];
            end else if (avs_address == `OCM_ADDR_THRESH) begin
                thresh_nxt = avs_writedata[11:0];
            end else if (avs_address == `OCM_ADDR_MINP) begin
                minp_nxt = avs_writedata[7:0];
            end else if (avs_address == `OCM_ADDR_STATUS) begin
                status_nxt = status_r & ~avs_writedata[2:0]; // write one to clear
            end else if (avs_address == `OCM_ADDR_MASK) begin
                mask_nxt = avs_writedata[2:0];
            end
            // unmapped writes are dropped
        end
        // a new event beats a clear in the same cycle
        status_nxt = status_nxt | ch_rise;
        irq_nxt = |(status_nxt & mask_nxt);
    end

    // slave state resets to a quiet block: nothing trips with the trip level at its top,
    // no event is pending, no interrupt is enabled and the straps alone decide pin C
    // slave registers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wait_r <= 1'b1;
            rdata_r <= 32'h0000_0000;
            ctrl_r <= `OCM_CTRL_RST;
            thresh_r <= `OCM_THRESH_RST;
            minp_r <= `OCM_MINP_RST;
            status_r <= `OCM_FLAGS_RST;
            mask_r <= `OCM_FLAGS_RST;
            irq_r <= 1'b0;
        end else begin
            wait_r <= wait_nxt;
            rdata_r <= rdata_nxt;
            ctrl_r <= ctrl_nxt;
            thresh_r <= thresh_nxt;
            minp_r <= minp_nxt;
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign avs_waitrequest = wait_r;
    assign avs_readdata = rdata_r;
    assign irq = irq_r;
endmodule // ocm_top

// file: hw/ocm_defines.svh
// register offsets, field positions, reset values and counts of the over-range / clock-out block
`ifndef OCM_DEFINES_SVH
`define OCM_DEFINES_SVH

// byte addresses of the register words
`define OCM_ADDR_CTRL 5'h00
`define OCM_ADDR_THRESH 5'h04
`define OCM_ADDR_MINP 5'h08
`define OCM_ADDR_STATUS 5'h0C
`define OCM_ADDR_MASK 5'h10
`define OCM_ADDR_STATE 5'h14

// control word fields
`define OCM_CTRL_OVR_EN 0
`define OCM_CTRL_SEL_LO 1
`define OCM_CTRL_SEL_HI 2
`define OCM_CTRL_DIS 3
`define OCM_CTRL_W 4

// state word fields
`define OCM_STATE_SRC_LO 4
`define OCM_STATE_SRC_HI 5

// widths
`define OCM_SAMPLE_W 12
`define OCM_MINP_W 8
`define OCM_NCH 3

// reset values
`define OCM_CTRL_RST 4'h0
`define OCM_THRESH_RST 12'hFFF
`define OCM_MINP_RST 8'h01
`define OCM_FLAGS_RST 3'h0

`endif

// file: hw/ocm_pkg.sv
// types shared by the over-range / clock-out block
package ocm_pkg;

    // what drives the channel C pin
    typedef enum logic [1:0] {
        OCM_SRC_OVR = 2'b00,
        OCM_SRC_REPEAT = 2'b01,
        OCM_SRC_DIV2 = 2'b10,
        OCM_SRC_DIV4 = 2'b11
    } ocm_clksrc_t;

endpackage

// file: hw/ocm_chan_if.sv
// bundle between the top and one over-range pulse stretcher
`timescale 1ns/100ps
interface ocm_chan_if;
    logic [11:0] sample; // converter code of this channel
    logic [11:0] threshold; // shared trip level
    logic [7:0] min_pulse; // least high time in cycles
    logic active; // channel exists in this variant
    logic level; // stretched over-range level
    logic rise; // one-cycle pulse on assertion

    modport top (output sample, output threshold, output min_pulse, output active,
                 input level, input rise);
    modport chan (input sample, input threshold, input min_pulse, input active,
                  output level, output rise);
endinterface

// file: hw/ocm_stretch.sv
// one channel over-range detector with minimum pulse stretching
`timescale 1ns/100ps
`include "ocm_defines.svh"
module ocm_stretch
    import ocm_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    ocm_chan_if.chan bus
);
    logic level_r, level_nxt; // stretched output
    logic rise_r, rise_nxt; // assertion event
    logic [`OCM_MINP_W-1:0] cnt_r, cnt_nxt; // cycles still owed after assertion
    logic over; // input beyond trip level

    // strict compare: equal to threshold is not over-range
    assign over = bus.active && (bus.sample > bus.threshold);

    // next level and hold counter
    always_comb begin
        level_nxt = level_r;
        cnt_nxt = cnt_r;
        rise_nxt = 1'b0;
        if (!level_r) begin
            if (over) begin
                level_nxt = 1'b1;
                rise_nxt = 1'b1;
                // zero is taken as one cycle, avoids wrap of the counter
                cnt_nxt = (bus.min_pulse == 8'h00) ? 8'h00 : bus.min_pulse - 8'h01;
            end
        end else begin
            if (cnt_r != 8'h00) begin
                cnt_nxt = cnt_r - 8'h01;
            end
            level_nxt = over || (cnt_r != 8'h00);
        end
    end

    // registers only
    always_ff @(posedge clk) begin
        if (!resetn) begin
            level_r <= 1'b0;
            rise_r <= 1'b0;
            cnt_r <= 8'h00;
        end else begin
            level_r <= level_nxt;
            rise_r <= rise_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign bus.level = level_r;
    assign bus.rise = rise_r;
endmodule // ocm_stretch

// file: verif/ocm_monitor.sv
// assertion checker of the over-range and clock-out pins
`timescale 1ns/100ps
`include "ocm_defines.svh"
module ocm_monitor
    import ocm_pkg::*;
#(
    parameter int NUM_CHANNELS = 4 // 1, 2 or 4 channels
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [11:0] sample_a,
    input wire logic [11:0] sample_b,
    input wire logic [11:0] sample_c,
    input wire logic ref_clk_diff,
    input wire logic ref_clk_se,
    input wire logic ref_select_se,
    input wire logic pll_enable,
    input wire logic power_down_pin,
    input wire logic [1:0] clock_output_select,
    input wire logic overrange_out_a,
    input wire logic overrange_out_b,
    input wire logic overrange_or_clock_out_c,
    input wire logic reference_clock_repeat_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    logic [3:0] ctrl_r; // shadow of the control word
    logic [11:0] thr_r; // shadow trip level
    logic [7:0] minp_r; // shadow minimum pulse
    logic [8:0] hi_r; // cycles pin A has stood high
    logic [8:0] q_r; // cycles input A stayed at or below trip
    logic wr; // write accepted at this edge
    logic pick; // reference the straps select
    logic [8:0] mpe; // minimum pulse, zero acts as one
    ocm_clksrc_t src; // what pin C should carry
    assign wr = avs_write && !avs_waitrequest;
    assign pick = ref_select_se ? ref_clk_se : ref_clk_diff;
    assign mpe = (minp_r == 8'h00) ? 9'h001 : {1'h0, minp_r};
    assign src = (ctrl_r[3] || !pll_enable) ? OCM_SRC_OVR
        : ocm_clksrc_t'(ctrl_r[0] ? ctrl_r[2:1] : clock_output_select);
    // shadows track only accepted writes, so a held request is not counted twice
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrl_r <= 4'h0;
            thr_r <= 12'hFFF;
            minp_r <= 8'h01;
            hi_r <= 9'h000;
            q_r <= 9'h000;
        end else begin
            if (wr && avs_address == `OCM_ADDR_CTRL) ctrl_r <= avs_writedata[3:0];
            if (wr && avs_address == `OCM_ADDR_THRESH) thr_r <= avs_writedata[11:0];
            if (wr && avs_address == `OCM_ADDR_MINP) minp_r <= avs_writedata[7:0];
            hi_r <= overrange_out_a ? hi_r + 9'h001 : 9'h000;
            q_r <= (sample_a > thr_r) ? 9'h000 : q_r + {8'h00, q_r != 9'h1FF};
        end
    end
    a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("no answer after one wait");
    a_bus_short_ack: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("answer longer than one cycle");
    a_bus_unmapped: assert property (avs_read && !avs_waitrequest && avs_address > `OCM_ADDR_STATE
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
    a_trip_a: assert property (sample_a > thr_r |-> ##2 overrange_out_a)
        else $error("pin A missed a trip");
    a_trip_b: assert property (NUM_CHANNELS >= 2 && sample_b > thr_r |-> ##2 overrange_out_b)
        else $error("pin B missed a trip");
    a_trip_c: assert property (NUM_CHANNELS == 4 && sample_c > thr_r && src == OCM_SRC_OVR
        ##1 src == OCM_SRC_OVR |=> overrange_or_clock_out_c) else $error("pin C missed a trip");
    a_min_pulse: assert property ($fell(overrange_out_a) |-> hi_r >= mpe)
        else $error("pin A pulse too short");
    a_release_a: assert property (q_r > mpe + 9'h003 |-> !overrange_out_a)
        else $error("pin A stuck high");
    a_refo_copy: assert property (pll_enable && !power_down_pin && $past(resetn)
        |=> reference_clock_repeat_out == $past(pick, 2)) else $error("repeat not a copy");
    a_refo_stop: assert property (power_down_pin || !pll_enable
        |=> !reference_clock_repeat_out) else $error("repeat not stopped");
    a_c_stop: assert property (power_down_pin && src != OCM_SRC_OVR
        |=> !overrange_or_clock_out_c) else $error("pin C clock not stopped");
    a_c_repeat: assert property (src == OCM_SRC_REPEAT && !power_down_pin && $past(resetn)
        |=> overrange_or_clock_out_c == $past(pick, 2)) else $error("pin C not a copy");
endmodule // ocm_monitor
bind ocm_top ocm_monitor #(.NUM_CHANNELS(NUM_CHANNELS)) ocm_monitor_i (.*);

// file: verif/ocm_far_end.sv
// board logic beyond the pins: counts rising edges of the clocks it receives
`timescale 1ns/100ps
module ocm_far_end (
    input wire logic clk,
    input wire logic clr, // restart both counts
    input wire logic pin_c, // channel C status or clock
    input wire logic refo, // forwarded reference
    output logic [15:0] edges_c, // rising edges on pin C
    output logic [15:0] edges_r // rising edges on the repeat
);
    logic c_r, r_r; // last levels seen
    // sampled on the local clock, so only clocks below half its rate count true
    always_ff @(posedge clk) begin
        c_r <= pin_c;
        r_r <= refo;
        edges_c <= clr ? 16'h0 : edges_c + {15'h0, pin_c & ~c_r};
        edges_r <= clr ? 16'h0 : edges_r + {15'h0, refo & ~r_r};
    end
endmodule // ocm_far_end

// file: verif/tb_ocm_top.sv
// self-checking bench of the over-range and clock-out block
`timescale 1ns/100ps
`include "ocm_defines.svh"
module tb_ocm_top;
    logic clk, resetn, avs_read, avs_write, avs_waitrequest, irq, clr, se_run;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [11:0] sample_a, sample_b, sample_c;
    logic ref_clk_diff, ref_clk_se, ref_select_se, pll_enable, power_down_pin;
    logic [1:0] clock_output_select;
    logic overrange_out_a, overrange_out_b, overrange_or_clock_out_c, reference_clock_repeat_out;
    logic [2:0] rc; // reference divider, period of eight clocks
    logic [15:0] edges_c, edges_r;
    logic [2:0] pins; // status pins C, B, A
    logic one_a, one_b, one_c; // pins of the single-channel variant
    logic [2:0] seen1; // pins of that variant seen high during one trip
    int num_errors, num_checks, cyc, n, w;
    assign pins = {overrange_or_clock_out_c, overrange_out_b, overrange_out_a};
    ocm_top ocm_top_i (.*);
    ocm_far_end ocm_far_end_i (.clk, .clr, .pin_c(overrange_or_clock_out_c),
        .refo(reference_clock_repeat_out), .edges_c, .edges_r);
    // single-channel variant on the same inputs: only its pin A may ever trip
    if (1) begin : g_single
        ocm_top #(.NUM_CHANNELS(1)) ocm_top_i (.*, .avs_readdata(), .avs_waitrequest(), .irq(),
            .overrange_out_a(one_a), .overrange_out_b(one_b), .overrange_or_clock_out_c(one_c),
            .reference_clock_repeat_out());
    end
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // only one reference runs at a time, so a copy of the wrong one shows
    always @(posedge clk) begin
        rc <= rc + 3'h1;
        if (se_run) ref_clk_se <= rc[2];
        else ref_clk_diff <= rc[2];
    end
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            num_errors++;
            results();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // one access, held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata; // taken at the edge that sees waitrequest low
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    // one clock-out setup, then a 64-cycle edge count at the far end
    task automatic ck(input logic [3:0] cw, input logic [1:0] st, input logic pe, input logic pd,
        input logic se, input int ec, input int er);
        bus(1'b1, `OCM_ADDR_CTRL, {28'h0, cw});
        clock_output_select <= st;
        pll_enable <= pe;
        power_down_pin <= pd;
        ref_select_se <= se;
        se_run <= se;
        repeat (40) @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (64) @(posedge clk);
        @(negedge clk);
        chk({16'h0, edges_c}, 32'(ec));
        chk({16'h0, edges_r}, 32'(er));
    endtask
    task automatic results();
        $display("mismatches %0d, checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        {resetn, avs_read, avs_write, clr, se_run, ref_clk_diff, ref_clk_se} = 7'h0;
        {avs_address, avs_writedata, sample_a, sample_b, sample_c} = 73'h0;
        {ref_select_se, power_down_pin, clock_output_select, rc} = 7'h0;
        pll_enable = 1'b1;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        rdchk(`OCM_ADDR_CTRL, 32'h0);
        rdchk(`OCM_ADDR_THRESH, 32'hFFF);
        rdchk(`OCM_ADDR_MINP, 32'h1);
        rdchk(`OCM_ADDR_STATUS, 32'h0);
        rdchk(5'h18, 32'h0);
        bus(1'b1, `OCM_ADDR_THRESH, 32'h100);
        bus(1'b1, `OCM_ADDR_MINP, 32'h4);
        bus(1'b1, `OCM_ADDR_MASK, 32'h6); // channel A masked
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            {sample_c, sample_b, sample_a} <= 36'h100 << (12 * i); // equal does not trip
            @(posedge clk);
            {sample_c, sample_b, sample_a} <= 36'h101 << (12 * i);
            @(posedge clk);
            {sample_c, sample_b, sample_a} <= 36'h0;
            n = 0;
            seen1 = 3'h0;
            while (pins[i] !== 1'b1 && n < 8) begin
                @(negedge clk);
                seen1 = seen1 | {one_c, one_b, one_a};
                n++;
            end
            w = 0;
            while (pins[i] === 1'b1 && w < 300) begin
                @(negedge clk);
                seen1 = seen1 | {one_c, one_b, one_a};
                w++;
            end
            chk(32'(w), 32'h4);
            chk({29'h0, seen1}, {29'h0, 3'(i == 0)});
            chk({31'h0, irq}, {31'h0, i != 0});
            rdchk(`OCM_ADDR_STATUS, 32'h1 << i);
            bus(1'b1, `OCM_ADDR_STATUS, 32'h1 << i);
            rdchk(`OCM_ADDR_STATUS, 32'h0);
            chk({31'h0, irq}, 32'h0);
        end
        ck(4'h0, 2'h1, 1'b1, 1'b0, 1'b0, 8, 8);
        ck(4'h0, 2'h2, 1'b1, 1'b0, 1'b0, 4, 8);
        ck(4'h0, 2'h3, 1'b1, 1'b0, 1'b0, 2, 8);
        ck(4'h0, 2'h3, 1'b0, 1'b0, 1'b0, 0, 0);
        ck(4'h8, 2'h3, 1'b1, 1'b0, 1'b0, 0, 8);
        ck(4'h7, 2'h0, 1'b1, 1'b0, 1'b0, 2, 8);
        ck(4'h3, 2'h0, 1'b1, 1'b0, 1'b0, 8, 8);
        ck(4'h0, 2'h1, 1'b1, 1'b1, 1'b0, 0, 0);
        ck(4'h0, 2'h1, 1'b1, 1'b0, 1'b1, 8, 8);
        results();
    end
endmodule // tb_ocm_top
